// File: core/step_dir_microstep_translator.sv
// step and direction translator driving two phase current table entries
`timescale 1ns/10ps
`default_nettype none
module step_dir_microstep_translator #(
  parameter int unsigned INDEX_W = translator_pkg::INDEX_W
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // motion pins from the controller
  input  wire logic                  step_in,
  input  wire logic                  direction_in,
  input  wire logic                  resolution_select_low,
  input  wire logic                  resolution_select_high,
  // configuration bits held by the serial side
  input  wire logic                  res_reg_wr,
  input  wire logic [1:0]            res_reg_wdata,
  // serial step change, two's complement
  input  wire logic                  serial_step_valid,
  input  wire logic [5:0]            serial_step_change,
  // translator state
  output logic [5:0]                 step_angle_q,
  output logic [1:0]                 resolution_q,
  // phase current dac codes: sign bit and magnitude
  output logic                       phase_a_neg_q,
  output logic [5:0]                 phase_a_mag_q,
  output logic                       phase_b_neg_q,
  output logic [5:0]                 phase_b_mag_q
);

  // elaboration guards: the wrap arithmetic and the table assume six bits
  if (INDEX_W != 6) begin : g_index_w_check
    $error("translator serves a 64 entry cycle only");
  end
  if (translator_pkg::DAC_W != 6) begin : g_dac_w_check
    $error("phase table holds six bit magnitudes only");
  end

  // timing, counted in rising edges from the first one that samples step high:
  //   that edge loads the first synchroniser stage,
  //   the next one loads the second stage and raises the edge pulse,
  //   the one after that loads the new index,
  //   and one edge later the phase codes follow it.
  // a controller therefore sees the move three edges after its rise and the
  // currents four edges after; the detector needs the level low for at least
  // one sample between rises, or two steps merge into one.
  // selects and direction feed the move decode at the detecting cycle, so
  // they must settle a few cycles before the rise that they qualify.
  // a serial change is a one cycle add and needs no synchroniser.

  // synchroniser stages; the first stage is read only by the second
  logic                        step_s1_q;
  logic                        step_s2_q;
  logic                        step_s3_q;
  logic                        dir_s1_q;
  logic                        dir_s2_q;
  // select register and the resolution the next edge will use
  logic [1:0]                  res_reg_q;
  logic [1:0]                  res_eff;
  translator_pkg::resolution_t res_mode;
  // edge and direction as seen by the move decode
  logic                        step_rise;
  logic                        forward;
  // grid arithmetic for the next step position
  logic [5:0]                  grid;
  logic [5:0]                  base;
  logic [5:0]                  down;
  logic [5:0]                  snapped;
  logic [5:0]                  next_index;
  // target of a serial move
  logic [5:0]                  serial_index;
  // phase lookup; lane 0 carries phase a, lane 1 phase b
  logic [4:0]                  offset_sin;
  logic [4:0]                  offset_cos;
  logic [5:0]                  lane_mag_d [2];
  logic                        lane_neg_d [2];

  // default quarter sine magnitudes for offsets 0..16; sixteen is full scale
  // codes above sixteen never occur; the default supplies sixteen and keeps the case complete
  function automatic logic [5:0] sine_mag(input logic [4:0] k);
    logic [5:0] m;
    m = 6'h00;
    unique case (k)
      5'd0:  m = 6'h00;
      5'd1:  m = 6'h06;
      5'd2:  m = 6'h0c;
      5'd3:  m = 6'h12;
      5'd4:  m = 6'h18;
      5'd5:  m = 6'h1d;
      5'd6:  m = 6'h23;
      5'd7:  m = 6'h27;
      5'd8:  m = 6'h2c;
      5'd9:  m = 6'h30;
      5'd10: m = 6'h34;
      5'd11: m = 6'h37;
      5'd12: m = 6'h3b;
      5'd13: m = 6'h3c;
      5'd14: m = 6'h3e;
      5'd15: m = 6'h3f;
      default: m = translator_pkg::FULL_SCALE;
    endcase
    return m;
  endfunction : sine_mag

  // step chain; reset low matches the idle pin, so no false edge follows
  // reset, and the third stage only serves the edge detector
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      step_s1_q <= 1'b0;
      step_s2_q <= 1'b0;
      step_s3_q <= 1'b0;
    end else begin
      step_s1_q <= step_in;
      step_s2_q <= step_s1_q;
      step_s3_q <= step_s2_q;
    end
  end

  // direction chain, as deep as the step chain up to its second stage, so
  // the level that rode along with the step is the one that gets used
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dir_s1_q <= 1'b0;
      dir_s2_q <= 1'b0;
    end else begin
      dir_s1_q <= direction_in;
      dir_s2_q <= dir_s1_q;
    end
  end

  // one cycle pulse per rise of the synchronised step level; a held high
  // level never repeats the move
  assign step_rise = step_s2_q & ~step_s3_q;
  assign forward   = dir_s2_q;

  // configuration select bits; cleared at reset so the pins rule alone
  // until the serial side writes them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      res_reg_q <= translator_pkg::RES_REG_RST;
    end else if (res_reg_wr) begin
      res_reg_q <= res_reg_wdata;
    end
  end

  // pins are used live; only the step edge commits the choice, so a change
  // between edges takes effect from the next edge onward
  assign res_eff  = {resolution_select_high | res_reg_q[1],
                     resolution_select_low  | res_reg_q[0]};
  assign res_mode = translator_pkg::resolution_t'(res_eff);

  // grid pitch per resolution; a pitch of one is plain sixteenth stepping
  // and falls out of the same rounding as the coarser modes
  always_comb begin
    grid = 6'h01;
    unique case (res_mode)
      translator_pkg::RES_SIXTEENTH: begin
        grid = 6'h01;
      end
      translator_pkg::RES_QUARTER: begin
        grid = 6'h04;
      end
      translator_pkg::RES_HALF: begin
        grid = 6'h08;
      end
      translator_pkg::RES_FULL: begin
        grid = 6'h10;
      end
    endcase
  end

  // the full step grid sits eight above each multiple of sixteen; shift it onto
  // multiples of sixteen so one rounding rule serves every resolution
  always_comb begin
    if (res_mode == translator_pkg::RES_FULL) begin
      base = step_angle_q - translator_pkg::FULL_OFFSET;
    end else begin
      base = step_angle_q;
    end
  end

  // round down to the grid; the pitch is a power of two, so a mask suffices
  // and no divider is needed
  assign down = base & ~(grid - 6'h01);

  // forward always lands on the next grid point above; reverse from off the
  // grid stops at the point just below, from on the grid moves one pitch.
  // six bit arithmetic gives the wrap past either end for free
  always_comb begin
    if (forward) begin
      snapped = down + grid;
    end else if (down != base) begin
      snapped = down;
    end else begin
      snapped = down - grid;
    end
  end

  // move the full step grid back onto the diagonals, both phases driven
  always_comb begin
    if (res_mode == translator_pkg::RES_FULL) begin
      next_index = snapped + translator_pkg::FULL_OFFSET;
    end else begin
      next_index = snapped;
    end
  end

  // serial moves add the two's complement change and ignore the selection;
  // the host picks the size, so any index is reachable this way
  assign serial_index = step_angle_q + serial_step_change;

  // index update; a serial change arriving with a step edge is dropped, the
  // step wins since it comes from a pin that cannot be asked to repeat itself
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      step_angle_q <= translator_pkg::INDEX_RESET;
    end else if (step_rise) begin
      step_angle_q <= next_index;
    end else if (serial_step_valid) begin
      step_angle_q <= serial_index;
    end
  end

  // effective resolution, registered so the controller can observe it; it
  // lags the pins by one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resolution_q <= translator_pkg::RES_REG_RST;
    end else begin
      resolution_q <= res_eff;
    end
  end

  // offsets into the quarter sine: low four bits for the sine lane, the
  // remainder to sixteen for the cosine lane
  assign offset_sin = {1'b0, step_angle_q[3:0]};
  assign offset_cos = 5'd16 - offset_sin;

  // quadrant from the top two bits; phase b leads phase a by ninety degrees,
  // so index zero gives b full positive and a zero. a zero magnitude is
  // never marked negative, which keeps the dac sign quiet at the crossings
  always_comb begin
    lane_mag_d[0] = 6'h00;
    lane_mag_d[1] = 6'h00;
    lane_neg_d[0] = 1'b0;
    lane_neg_d[1] = 1'b0;
    unique case (step_angle_q[5:4])
      2'd0: begin
        lane_mag_d[0] = sine_mag(offset_sin);
        lane_mag_d[1] = sine_mag(offset_cos);
        lane_neg_d[0] = 1'b0;
        lane_neg_d[1] = 1'b0;
      end
      2'd1: begin
        lane_mag_d[0] = sine_mag(offset_cos);
        lane_mag_d[1] = sine_mag(offset_sin);
        lane_neg_d[0] = 1'b0;
        lane_neg_d[1] = offset_sin != 5'd0;
      end
      2'd2: begin
        lane_mag_d[0] = sine_mag(offset_sin);
        lane_mag_d[1] = sine_mag(offset_cos);
        lane_neg_d[0] = offset_sin != 5'd0;
        lane_neg_d[1] = 1'b1;
      end
      2'd3: begin
        lane_mag_d[0] = sine_mag(offset_cos);
        lane_mag_d[1] = sine_mag(offset_sin);
        lane_neg_d[0] = 1'b1;
        lane_neg_d[1] = 1'b0;
      end
    endcase
  end

  // phase a dac code, registered so the outputs come straight from flops;
  // one cycle behind the index
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_a_neg_q <= 1'b0;
      phase_a_mag_q <= 6'h00;
    end else begin
      phase_a_neg_q <= lane_neg_d[0];
      phase_a_mag_q <= lane_mag_d[0];
    end
  end

  // phase b dac code; full positive out of reset to match index zero
  // before the first lookup has run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_b_neg_q <= 1'b0;
      phase_b_mag_q <= translator_pkg::FULL_SCALE;
    end else begin
      phase_b_neg_q <= lane_neg_d[1];
      phase_b_mag_q <= lane_mag_d[1];
    end
  end

endmodule : step_dir_microstep_translator
`default_nettype wire

// File: core/translator_pkg.sv
// constants and types shared by the step and direction translator
package translator_pkg;

  localparam int unsigned        INDEX_W      = 6;
  localparam int unsigned        DAC_W        = 6;
  localparam logic [5:0]         INDEX_RESET  = 6'h00;
  localparam logic [1:0]         RES_REG_RST  = 2'h0;
  // phase b full scale magnitude at index zero, sign bit separate
  localparam logic [5:0]         FULL_SCALE   = 6'h3f;
  // full step positions sit at eight plus a multiple of sixteen
  localparam logic [5:0]         FULL_OFFSET  = 6'h08;

  typedef enum logic [1:0] {
    RES_FULL,
    RES_HALF,
    RES_QUARTER,
    RES_SIXTEENTH
  } resolution_t;

endpackage : translator_pkg

// File: sim/step_dir_microstep_translator_tb.sv
// self-checking bench for the step and direction translator
`timescale 1ns/10ps
`default_nettype none
module step_dir_microstep_translator_tb;
  logic       clk = 1'b0, reset = 1'b1, fire = 1'b0, step_in, dir = 1'b1, wr = 1'b0, sv = 1'b0;
  logic [1:0] sel = 2'h0, wdata = 2'h0, res;
  logic [5:0] idx, a_mag, b_mag, sc = 6'h00;
  logic       a_neg, b_neg;
  int         failures = 0, n_checks = 0;
  step_host step_host_inst (.clk(clk), .fire(fire), .step_out(step_in));
  step_dir_microstep_translator #(.INDEX_W(6)) step_dir_microstep_translator_inst (
    .clk(clk), .reset(reset), .step_in(step_in), .direction_in(dir),
    .resolution_select_low(sel[0]), .resolution_select_high(sel[1]), .res_reg_wr(wr),
    .res_reg_wdata(wdata), .serial_step_valid(sv), .serial_step_change(sc),
    .step_angle_q(idx), .resolution_q(res), .phase_a_neg_q(a_neg), .phase_a_mag_q(a_mag),
    .phase_b_neg_q(b_neg), .phase_b_mag_q(b_mag));
  initial forever #5 clk = ~clk;
  task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  // direction settles well before the rise, result read once phases land
  task automatic mv(input logic d, input logic [5:0] exp);
    dir = d;
    repeat (4) @(negedge clk);
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    repeat (12) @(negedge clk);
    cmp("step_angle_q", {2'h0, exp}, {2'h0, idx});
  endtask : mv
  task automatic t_reset;
    cmp("step_angle_q", 8'h00, {2'h0, idx});
    cmp("resolution_q", 8'h00, {6'h00, res});
    cmp("phase_b_mag_q", 8'h3f, {2'h0, b_mag});
    cmp("phase_a_mag_q", 8'h00, {2'h0, a_mag});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_sixteenth;
    sel = 2'h3;
    mv(1'b1, 6'h01);
    mv(1'b0, 6'h00);
    mv(1'b0, 6'h3f);
    for (int i = 0; i < 4; i++) mv(1'b0, 6'h3e - i[5:0]);
    $display("t_sixteenth done");
  endtask : t_sixteenth
  // from 59: quarter, back, half, then full steps round the cycle
  task automatic t_change;
    sel = 2'h2;
    mv(1'b1, 6'h3c);
    sel = 2'h3;
    mv(1'b0, 6'h3b);
    sel = 2'h1;
    mv(1'b1, 6'h00);
    mv(1'b1, 6'h08);
    sel = 2'h0;
    for (int i = 1; i < 5; i++) mv(1'b1, 6'h08 + 6'h10 * i[5:0]);
    mv(1'b0, 6'h38);
    sel = 2'h2;
    mv(1'b0, 6'h34);
    $display("t_change done");
  endtask : t_change
  // pins low so the register alone picks sixteenth step
  task automatic t_reg;
    sel = 2'h0;
    wr = 1'b1;
    wdata = 2'h3;
    @(negedge clk);
    wr = 1'b0;
    mv(1'b1, 6'h35);
    cmp("resolution_q", 8'h03, {6'h00, res});
    $display("t_reg done");
  endtask : t_reg
  // full step selected, a serial move of -25 lands off grid at 28; then park
  task automatic t_serial;
    wr = 1'b1;
    wdata = 2'h0;
    @(negedge clk);
    wr = 1'b0;
    sv = 1'b1;
    sc = 6'h27;
    @(negedge clk);
    sv = 1'b0;
    repeat (3) @(negedge clk);
    cmp("step_angle_q", 8'h1c, {2'h0, idx});
    cmp("phase_a_mag_q", 8'h18, {2'h0, a_mag});
    cmp("phase_a_neg_q", 8'h00, {7'h00, a_neg});
    cmp("phase_b_mag_q", 8'h3b, {2'h0, b_mag});
    cmp("phase_b_neg_q", 8'h01, {7'h00, b_neg});
    mv(1'b1, 6'h28);
    cmp("phase_a_neg_q", 8'h01, {7'h00, a_neg});
    cmp("phase_b_neg_q", 8'h01, {7'h00, b_neg});
    cmp("phase_a_mag_q", {2'h0, b_mag}, {2'h0, a_mag});
    $display("t_serial done");
  endtask : t_serial
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_sixteenth();
    t_change();
    t_reg();
    t_serial();
    tally_and_finish();
  end
  // run needs about 3.4 us; a hang is cut at 100 us
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule : step_dir_microstep_translator_tb
`default_nettype wire

// File: sim/step_host.sv
// controller model that issues step pulses on request
`timescale 1ns/10ps
`default_nettype none
module step_host (
  input  wire logic clk,
  input  wire logic fire,
  output logic      step_out
);
  logic [2:0] cnt_q = 3'h0;
  // fire is taken on the rising edge; three more cycles low then four high
  always @(posedge clk) begin
    if (fire || cnt_q != 3'h0) cnt_q <= cnt_q + 3'h1;
  end
  assign step_out = cnt_q[2];
endmodule : step_host
`default_nettype wire

// File: sim/translator_sva.sv
// port checks for the step and direction translator
`timescale 1ns/10ps
`default_nettype none
module translator_sva #(parameter int unsigned INDEX_W = 6) (
  // clock, reset, pins and the phase b sign
  input wire logic       clk, reset, step_in, direction_in, serial_step_valid,
  input wire logic       resolution_select_low, resolution_select_high, phase_b_neg_q,
  // outputs
  input wire logic [5:0] step_angle_q, phase_a_mag_q, phase_b_mag_q,
  input wire logic [1:0] resolution_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a detected rise lands three edges later
  chk_fwd_sixteenth: assert property ($rose(step_in) && direction_in && resolution_q == 2'h3
    |-> ##3 step_angle_q == $past(step_angle_q) + 6'h01) else $error("forward step wrong");
  chk_rev_sixteenth: assert property ($rose(step_in) && !direction_in && resolution_q == 2'h3
    |-> ##3 step_angle_q == $past(step_angle_q) - 6'h01) else $error("reverse step wrong");
  chk_full_grid: assert property ($rose(step_in) && resolution_q == 2'h0
    |-> ##3 step_angle_q[3:0] == 4'h8) else $error("full step off grid");
  chk_half_grid: assert property ($rose(step_in) && resolution_q == 2'h1
    |-> ##3 step_angle_q[2:0] == 3'h0) else $error("half step off grid");
  chk_quarter_grid: assert property ($rose(step_in) && resolution_q == 2'h2
    |-> ##3 step_angle_q[1:0] == 2'h0) else $error("quarter step off grid");
  chk_one_per_edge: assert property ($changed(step_angle_q)
    |-> ($past(step_in, 3) && !$past(step_in, 4)) || $past(serial_step_valid))
    else $error("index moved without edge");
  chk_zero_phase: assert property ($past(step_angle_q) == 6'h00
    |-> phase_a_mag_q == 6'h00 && phase_b_mag_q == 6'h3f && !phase_b_neg_q) else $error("bad phase");
  chk_select_or: assert property (!$past(reset)
    |-> (resolution_q | ~$past({resolution_select_high, resolution_select_low})) == 2'h3)
    else $error("select pin ignored");
  cover property ($rose(step_in) && resolution_q == 2'h0);
  cover property ($rose(step_in) && resolution_q == 2'h1);
  cover property ($rose(step_in) && resolution_q == 2'h2);
  cover property ($past(serial_step_valid) && $changed(step_angle_q));
endmodule : translator_sva
bind step_dir_microstep_translator translator_sva #(.INDEX_W(INDEX_W)) translator_sva_inst (
  .clk(clk), .reset(reset), .step_in(step_in), .direction_in(direction_in),
  .serial_step_valid(serial_step_valid),
  .resolution_select_low(resolution_select_low), .resolution_select_high(resolution_select_high),
  .phase_b_neg_q(phase_b_neg_q), .step_angle_q(step_angle_q), .phase_a_mag_q(phase_a_mag_q),
  .phase_b_mag_q(phase_b_mag_q), .resolution_q(resolution_q));
`default_nettype wire
